/* ncie_pkg.sv */
// Purpose: Constants and types for the nibble core execute block.
// Assumes: One 250 MHz clock, synchronous active-low reset.
// Notes:   Register offsets are byte addresses on the AXI4-Lite slave.
////////////////////////////////////////////////////////////////////////////////
package ncie_pkg;
	localparam int AXI_AW = 8;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PC     = 8'h08;
	localparam logic [7:0] REG_TIMER  = 8'h0C;
	localparam logic [7:0] REG_RAS    = 8'h10;
	localparam logic [7:0] REG_PORT   = 8'h14;
	localparam int GREG_SEL_BIT = 7;
	// Field positions
	localparam int CTRL_WAKE_BIT = 4;
	localparam int STAT_CY_BIT   = 4;
	localparam int STAT_FL_BIT   = 5;
	localparam int STAT_SB_BIT   = 6;
	localparam int STAT_SP_BIT   = 7;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Instruction code bytes
	localparam logic [7:0] LO_TMR = 8'hFF;
	localparam logic [7:0] LO_ROM = 8'hF0;
	localparam logic [7:0] LO_IMM = 8'hF1;
	localparam logic [7:0] LO_ACC = 8'hF3;
	localparam logic [3:0] LO_REG_NIB = 4'hE;
	localparam logic [4:0] LO_PORT_TOP = 5'h1F;
	localparam logic [6:0] GRP_AND = 7'h7D;
	localparam logic [6:0] GRP_OR  = 7'h7E;
	localparam logic [6:0] GRP_XOR = 7'h7A;
	localparam logic [6:0] GRP_IN  = 7'h7F;
	localparam logic [6:0] GRP_OUT = 7'h72;
	localparam logic [7:0] HI_RD_T0  = 8'hFF;
	localparam logic [7:0] HI_RD_T1  = 8'hFE;
	localparam logic [7:0] HI_WR_T0  = 8'hE5;
	localparam logic [7:0] HI_WR_T1  = 8'hE4;
	localparam logic [7:0] HI_T_ROM  = 8'hF4;
	localparam logic [7:0] HI_T_IMM  = 8'hE6;
	localparam logic [7:0] HI_HALT   = 8'hE2;
	localparam logic [7:0] HI_STATUS_TEST   = 8'hE3;
	localparam logic [7:0] HI_INC    = 8'hF4;
	localparam logic [7:0] HI_RL     = 8'hFC;
	localparam logic [7:0] HI_RLZ    = 8'hFE;
	localparam logic [7:0] HI_CHECK_ALL_ONES   = 8'hFA;
	localparam logic [15:0] CODE_CALL = 16'hE6F2;
	localparam logic [15:0] CODE_RET  = 16'hE8F2;
	localparam logic [15:0] CODE_PG0  = 16'hE8F1;
	localparam logic [15:0] CODE_PG1  = 16'hE9F1;
	localparam logic [3:0] ALL_ONES = 4'hF;
	localparam logic [4:0] PTR_LO_IDX = 5'h00;
	localparam logic [4:0] PTR_HI_IDX = 5'h10;
	localparam logic [10:0] PC_STEP = 11'h001;

	typedef enum logic [2:0] {
		ST_FETCH = 3'b000, ST_OPND = 3'b001, ST_CALL2 = 3'b010,
		ST_CALL3 = 3'b011, ST_ROM = 3'b100, ST_STBY = 3'b101
	} ncie_st_e;

	typedef enum logic [2:0] {
		OP_AND = 3'b000, OP_OR = 3'b001, OP_XOR = 3'b010, OP_STATUS_TEST = 3'b011,
		OP_HALT = 3'b100, OP_TIMM = 3'b101, OP_TROM = 3'b110
	} ncie_op_e;

	typedef struct packed {
		ncie_st_e st;
		ncie_op_e op;
		logic phi;
		logic [3:0] acc;
		logic cy, fl, sp, stby, irst, rdy;
		logic [10:0] pc, ras;
		logic [9:0] tmr, rom_addr;
		logic [1:0] page;
		logic [3:0] hmask;
		logic [31:0][3:0] greg;
		logic [7:0][3:0] pout;
		logic [31:0] sy1_port, sy2_port;
		logic [3:0] sy1_stat, sy2_stat;
		logic awh, wh, ws, awrdy, wrdy, bvalid, arrdy, rvalid;
		logic [7:0] awa, wd;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
	} ncie_state_s;
endpackage

/* ncie_core.sv */
// Purpose: Execute unit of a 4-bit controller core with an AXI4-Lite view.
// Assumes: Instruction words arrive on a ready/valid port from same-clock
//          fetch logic; ROM data answers rom_addr within the same cycle.
// Notes:   Pins port_in and status_in are synchronised by two flops.
`timescale 1ns/1ns
`default_nettype none
module ncie_core
	import ncie_pkg::*;
(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [ncie_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [ncie_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic [15:0]               inst_word,
	input  wire logic                      inst_valid,
	output logic                           inst_ready,
	output logic [10:0]                    fetch_addr,
	output logic [9:0]                     rom_addr,
	input  wire logic [9:0]                rom_data,
	input  wire logic [31:0]               port_in,
	output logic [31:0]                    port_out,
	input  wire logic [3:0]                status_in,
	output logic [9:0]                     timer_value,
	output logic                           standby,
	output logic                           internal_reset
);
	import ncie_pkg::*;

	ncie_state_s r;
	ncie_state_s n;
	logic        take;
	logic        core_rst;
	logic        wake;
	logic        wr_wake;
	logic        wr_go;
	logic [7:0]  hi;
	logic [7:0]  lo;
	logic [6:0]  grp;
	logic        bank;
	logic [2:0]  pidx;
	logic        pval;
	logic [3:0]  pnib;
	logic [3:0]  gnib;
	logic [3:0]  rot;
	logic [32:0] rdv;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Logic ops on a nibble; returns {carry, result}
	function automatic logic [4:0] alu(input ncie_op_e op,
		input logic [3:0] a, input logic [3:0] b);
		logic [4:0] res;
		res = {1'b0, a};
		unique case (op)
			OP_AND:  res = {a[3] & b[3], a & b};
			OP_OR:   res = {1'b0, a | b};
			OP_XOR:  res = {a[3] & b[3], a ^ b};
			default: res = {1'b0, a};
		endcase
		return res;
	endfunction

	// True for the three accumulator logic groups
	function automatic logic is_alu(input logic [6:0] g);
		return (g == GRP_AND) || (g == GRP_OR) || (g == GRP_XOR);
	endfunction

	function automatic ncie_op_e op_of(input logic [6:0] g);
		ncie_op_e o;
		o = OP_AND;
		if (g == GRP_OR)
			o = OP_OR;
		else if (g == GRP_XOR)
			o = OP_XOR;
		return o;
	endfunction

	// Register read view for the bus
	function automatic logic [32:0] rd_mux(input ncie_state_s s,
		input logic [7:0] a);
		logic [32:0] v;
		v = {1'b1, 32'h0000_0000};
		if (a[GREG_SEL_BIT])
			v = {1'b1, 28'h000_0000, s.greg[a[6:2]]};
		else if (a[7:2] == REG_CTRL[7:2])
			v = {1'b1, 30'h0000_0000, s.page};
		else if (a[7:2] == REG_STATUS[7:2])
			v = {1'b1, 24'h00_0000, s.sp, s.stby, s.fl, s.cy, s.acc};
		else if (a[7:2] == REG_PC[7:2])
			v = {1'b1, 21'h00_0000, s.pc};
		else if (a[7:2] == REG_TIMER[7:2])
			v = {1'b1, 22'h00_0000, s.tmr};
		else if (a[7:2] == REG_RAS[7:2])
			v = {1'b1, 21'h00_0000, s.ras};
		else if (a[7:2] == REG_PORT[7:2])
			v = {1'b1, s.pout};
		else
			v = {1'b0, 32'h0000_0000};
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Field split of the incoming word; bank bit is the inverted low bit
	// of the first byte for every two-bank instruction form
	assign hi   = inst_word[15:8];
	assign lo   = inst_word[7:0];
	assign grp  = hi[7:1];
	assign bank = ~hi[0];
	// Port index 0,1,3,4 packs into two bits per bank
	assign pval = (lo[2:0] == 3'h0) || (lo[2:0] == 3'h1) ||
		(lo[2:0] == 3'h3) || (lo[2:0] == 3'h4);
	assign pidx = {bank, lo[2] ? 2'h3 : ((lo[1:0] == 2'h3) ? 2'h2 :
		lo[1:0])};
	assign pnib = r.sy2_port[{pidx, 2'h0} +: 4];
	assign gnib = r.greg[{bank, lo[3:0]}];
	assign rot  = {r.acc[2:0], r.acc[3]};

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus slave, then instruction execution
	always_comb begin
		n = r;
		n.irst = 1'b0;
		core_rst = 1'b0;
		wr_wake = 1'b0;
		take = r.rdy && inst_valid;
		// Read view held in a variable; a call result cannot be sliced
		rdv = rd_mux(r, s_axi_araddr);
		// Two-flop synchronisers; only the second stage is used
		n.sy1_port = port_in;
		n.sy2_port = r.sy1_port;
		n.sy1_stat = status_in;
		n.sy2_stat = r.sy1_stat;
		n.rom_addr = {r.page, r.greg[PTR_HI_IDX], r.greg[PTR_LO_IDX]};

		// Bus answers drop once accepted by the master
		if (s_axi_bready)
			n.bvalid = 1'b0;
		if (s_axi_rready)
			n.rvalid = 1'b0;
		// Address and data are held separately, so either may come first
		if (s_axi_awvalid && r.awrdy) begin
			n.awh = 1'b1;
			n.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wrdy) begin
			n.wh = 1'b1;
			n.wd = s_axi_wdata[7:0];
			n.ws = s_axi_wstrb[0];
		end
		wr_go = r.awh && r.wh && !r.bvalid;
		if (wr_go) begin
			n.awh = 1'b0;
			n.wh = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = rd_mux(r, r.awa) >> 32 != 33'h0 ? RESP_OKAY
				: RESP_SLVERR;
			// Only the low byte lane carries writable bits
			if (r.ws && r.awa[GREG_SEL_BIT])
				n.greg[r.awa[6:2]] = r.wd[3:0];
			else if (r.ws && r.awa[7:2] == REG_CTRL[7:2]) begin
				n.page = r.wd[1:0];
				wr_wake = r.wd[CTRL_WAKE_BIT];
			end
		end
		n.awrdy = !n.awh && !n.bvalid;
		n.wrdy = !n.wh && !n.bvalid;
		if (s_axi_arvalid && r.arrdy) begin
			n.rvalid = 1'b1;
			n.rdata = rdv[31:0];
			n.rresp = rdv[32] ? RESP_OKAY : RESP_SLVERR;
		end
		n.arrdy = !n.rvalid;

		// Key entry on the chosen status lines, or software, ends standby
		wake = ((r.sy2_stat & r.hmask) != 4'h0) || wr_wake;

		if (take)
			n.pc = r.pc + PC_STEP;

		unique case (r.st)
			ST_FETCH: begin
				if (take) begin
					if (lo == LO_TMR) begin
						if (hi == HI_RD_T0) begin
							n.acc = r.tmr[5:2];
							n.cy = 1'b0;
						end else if (hi == HI_RD_T1) begin
							n.acc = r.tmr[9:6];
							n.cy = 1'b0;
						end else if (hi == HI_WR_T0) begin
							// low nibble write, bit 0 cleared
							n.tmr[5:2] = r.acc;
							n.tmr[0] = 1'b0;
						end else if (hi == HI_WR_T1) begin
							// high nibble write, bit 1 cleared
							n.tmr[9:6] = r.acc;
							n.tmr[1] = 1'b0;
						end else if (hi == HI_T_ROM) begin
							n.op = OP_TROM;
							n.st = ST_ROM;
						end else if (hi == HI_T_IMM) begin
							n.op = OP_TIMM;
							n.st = ST_OPND;
						end
					end else if (lo[7:4] == LO_REG_NIB) begin
						if (hi == HI_STATUS_TEST) begin
							n.fl = (r.greg[{1'b0, lo[3:0]}] == r.sy2_stat);
						end else if (is_alu(grp)) begin
							{n.cy, n.acc} = alu(op_of(grp), r.acc, gnib);
						end
					end else if (lo == LO_ROM && is_alu(grp)) begin
						// ROM nibble fetched in the next cycle
						n.op = op_of(grp);
						n.phi = bank;
						n.st = ST_ROM;
					end else if (lo == LO_IMM) begin
						if (is_alu(grp)) begin
							n.op = op_of(grp);
							n.st = ST_OPND;
						end else if (hi == HI_HALT) begin
							n.op = OP_HALT;
							n.st = ST_OPND;
						end else if (hi == HI_STATUS_TEST) begin
							n.op = OP_STATUS_TEST;
							n.st = ST_OPND;
						end
					end else if (lo == LO_ACC) begin
						if (hi == HI_INC) begin
							n.acc = r.acc + 4'h1;
							n.cy = (r.acc == ALL_ONES);
						end else if (hi == HI_RL) begin
							n.acc = rot;
							n.cy = r.acc[3];
						end else if (hi == HI_RLZ) begin
							if (r.acc == 4'h0)
								core_rst = 1'b1;
							else begin
								n.acc = rot;
								n.cy = r.acc[3];
							end
						end else if (hi == HI_CHECK_ALL_ONES) begin
							n.cy = (r.acc == ALL_ONES);
						end
					end else if (lo[7:3] == LO_PORT_TOP && pval) begin
						if (grp == GRP_IN) begin
							n.acc = pnib;
							n.cy = 1'b0;
						end else if (grp == GRP_OUT) begin
							n.pout[pidx] = r.acc;
						end else if (is_alu(grp)) begin
							{n.cy, n.acc} = alu(op_of(grp), r.acc, pnib);
						end
					end else if (inst_word == CODE_CALL) begin
						n.st = ST_CALL2;
					end else if (inst_word == CODE_RET) begin
						// borrow out of the one-level stack
						if (r.sp == 1'b0)
							core_rst = 1'b1;
						else begin
							n.pc = r.ras;
							n.sp = 1'b0;
						end
					end
				end
			end
			ST_OPND: begin
				if (take) begin
					n.st = ST_FETCH;
					unique case (r.op)
						OP_HALT: begin
							n.hmask = inst_word[3:0];
							n.stby = 1'b1;
							n.st = ST_STBY;
						end
						OP_STATUS_TEST: n.fl = (inst_word[3:0] == r.sy2_stat);
						OP_TIMM: n.tmr = inst_word[9:0];
						default: {n.cy, n.acc} = alu(r.op, r.acc,
							inst_word[3:0]);
					endcase
				end
			end
			ST_CALL2: begin
				if (take) begin
					// A malformed page word abandons the call
					n.st = ST_FETCH;
					if (inst_word == CODE_PG0 || inst_word == CODE_PG1) begin
						n.phi = inst_word[8];
						n.st = ST_CALL3;
					end
				end
			end
			ST_CALL3: begin
				if (take) begin
					n.st = ST_FETCH;
					if (r.sp == 1'b1)
						core_rst = 1'b1;
					else begin
						n.sp = 1'b1;
						n.ras = r.pc + PC_STEP;
						n.pc = {r.phi, inst_word[9:0]};
					end
				end
			end
			ST_ROM: begin
				// rom_addr settled on the previous edge
				n.st = ST_FETCH;
				if (r.op == OP_TROM)
					n.tmr = rom_data;
				else
					{n.cy, n.acc} = alu(r.op, r.acc,
						r.phi ? rom_data[7:4] : rom_data[3:0]);
			end
			ST_STBY: begin
				if (wake) begin
					n.stby = 1'b0;
					n.st = ST_FETCH;
				end
			end
			default: n.st = ST_FETCH;
		endcase

		// Internal reset clears core state but keeps bus-side registers
		if (core_rst) begin
			n.st = ST_FETCH;
			n.acc = 4'h0;
			n.cy = 1'b0;
			n.fl = 1'b0;
			n.sp = 1'b0;
			n.pc = 11'h000;
			n.ras = 11'h000;
			n.tmr = 10'h000;
			n.pout = '0;
			n.stby = 1'b0;
			n.irst = 1'b1;
		end
		// Ready is registered, so it looks at the coming state
		n.rdy = !core_rst && (n.st == ST_FETCH || n.st == ST_OPND ||
			n.st == ST_CALL2 || n.st == ST_CALL3);
	end

	////////////////////////////////////////////////////////////////////////
	// all state in one register; flags only move when written
	always_ff @(posedge aclk) begin
		if (!aresetn)
			r <= '0;
		else
			r <= n;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state register
	assign s_axi_awready  = r.awrdy;
	assign s_axi_wready   = r.wrdy;
	assign s_axi_bvalid   = r.bvalid;
	assign s_axi_bresp    = r.bresp;
	assign s_axi_arready  = r.arrdy;
	assign s_axi_rvalid   = r.rvalid;
	assign s_axi_rresp    = r.rresp;
	assign s_axi_rdata    = r.rdata;
	assign inst_ready     = r.rdy;
	assign fetch_addr     = r.pc;
	assign rom_addr       = r.rom_addr;
	assign port_out       = r.pout;
	assign timer_value    = r.tmr;
	assign standby        = r.stby;
	assign internal_reset = r.irst;
endmodule
`default_nettype wire

/* ncie_assertions.sv */
// Purpose: Port-level properties of the nibble execute core.
// Assumes: Operand words on the instruction port stay below 16'h0400.
// Notes:   Helper logic follows call and halt word sequences.
`timescale 1ns/1ns
`default_nettype none
module ncie_assertions
	import ncie_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [15:0] inst_word,
	input wire logic        inst_valid,
	input wire logic        inst_ready,
	input wire logic [10:0] fetch_addr,
	input wire logic [31:0] port_out,
	input wire logic [9:0]  timer_value,
	input wire logic        standby,
	input wire logic        internal_reset
);
	logic        tk, tko, pgb, hp;
	logic [1:0]  cs;
	logic [10:0] ret, tgt;
	assign tk = inst_valid && inst_ready;
	assign tko = tk && inst_word[15:9] == GRP_OUT &&
		inst_word[7:3] == LO_PORT_TOP;
	// Word position inside a call; an internal reset abandons it
	always_ff @(posedge aclk) begin
		if (!aresetn || internal_reset) begin
			cs <= 2'h0;
			hp <= 1'b0;
		end else if (tk) begin
			hp <= cs == 2'h0 && inst_word == 16'hE2F1;
			if (cs == 2'h0) begin
				cs <= {1'b0, inst_word == CODE_CALL};
			end else if (cs == 2'h1) begin
				cs <= (inst_word == CODE_PG0 || inst_word == CODE_PG1) ? 2'h2 : 2'h0;
				pgb <= inst_word[8];
			end else begin
				cs <= 2'h0;
				ret <= fetch_addr + PC_STEP;
				tgt <= {pgb, inst_word[9:0]};
			end
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	call_target_a:
	assert property (tk && cs == 2'h2 |=> internal_reset || fetch_addr == tgt)
		else $error("call target not loaded");
	ret_restore_a:
	assert property (tk && cs == 2'h0 && inst_word == CODE_RET
		|=> internal_reset || fetch_addr == ret)
		else $error("return address not restored");
	inc_step_a:
	assert property (tk && inst_word == 16'hF4F3
		|=> fetch_addr == $past(fetch_addr) + PC_STEP)
		else $error("program counter did not step");
	rst_pulse_a:
	assert property (internal_reset |-> !inst_ready ##1 !internal_reset)
		else $error("internal reset pulse malformed");
	halt_enter_a:
	assert property (tk && hp |=> standby && !inst_ready)
		else $error("standby not entered");
	port_hold_a:
	assert property (!$stable(port_out)
		|-> internal_reset || $past(internal_reset) || $past(tko))
		else $error("port latch changed without a write");
	t0_clear_a:
	assert property (tk && inst_word == 16'hE5FF |=> !timer_value[0])
		else $error("timer bit 0 not cleared");
	t1_clear_a:
	assert property (tk && inst_word == 16'hE4FF |=> !timer_value[1])
		else $error("timer bit 1 not cleared");
	rom_cycle_a:
	assert property (tk && inst_word[7:0] == LO_ROM && (inst_word[15:9] == GRP_AND
		|| inst_word[15:9] == GRP_OR || inst_word[15:9] == GRP_XOR)
		|=> !inst_ready ##1 inst_ready)
		else $error("rom operand cycle missing");
endmodule
bind ncie_core ncie_assertions i_chk (.aclk, .aresetn, .inst_word, .inst_valid,
	.inst_ready, .fetch_addr, .port_out, .timer_value, .standby,
	.internal_reset);
`default_nettype wire

/* tb_top.sv */
// Purpose: Random and directed test of the nibble execute core.
// Assumes: ROM answers at once; pins settle within three cycles.
// Notes:   Expected core state lives in bench variables.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import ncie_pkg::*;
	logic        aclk = 0, aresetn = 0, inst_valid = 0;
	logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, lo;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0, b;
	logic [31:0] s_axi_wdata = 0, port_in = 0, s_axi_rdata, port_out, rd;
	logic [15:0] inst_word = 0;
	logic [3:0]  status_in = 0, acc = 0, v, gr [32];
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr, pg, k;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, inst_ready, standby, internal_reset;
	logic [10:0] fetch_addr, ra;
	logic [9:0]  rom_addr, rom_data, timer_value, tm = 0;
	logic        cy = 0, fl = 0;
	logic [31:0] po = 0;
	int          bad_count = 0, samples_checked = 0, cyc = 0, nrst = 0;
	ncie_core i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .inst_word, .inst_valid, .inst_ready, .fetch_addr,
		.rom_addr, .rom_data, .port_in, .port_out, .status_in, .timer_value,
		.standby, .internal_reset);
	////////////////////////////////////////////////////////////////////////////
	// Program memory stand-in: a fixed scramble of the address
	function automatic logic [9:0] rf(input logic [9:0] a);
		return {a[4:0] ^ 5'h15, a[9:5]};
	endfunction
	assign rom_data = rf(rom_addr);
	always #2 aclk = ~aclk;
	// Cycle ceiling and reset pulse count
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (internal_reset) nrst++;
		if (cyc == 30000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// One instruction word; the line is scrambled once released
	task automatic ins(input logic [15:0] w);
		inst_word <= w;
		inst_valid <= 1'b1;
		do @(posedge aclk); while (!inst_ready);
		inst_valid <= 1'b0;
		inst_word <= ~w;
		@(posedge aclk);
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic cmp_state();
		axr(REG_STATUS);
		chk(32'(rd[5:0]), 32'({fl, cy, acc}));
		chk(port_out, po);
		chk(32'(timer_value), 32'(tm));
	endtask
	// AND with zero then OR sets any value and clears carry
	task automatic setacc(input logic [3:0] d);
		ins(16'hFBF1);
		ins(16'h0000);
		ins(16'hFDF1);
		ins({12'h000, d});
		acc = d;
		cy = 1'b0;
	endtask
	// Internal reset wipes state but keeps registers and page
	task automatic wipe();
		acc = 4'h0;
		cy = 1'b0;
		fl = 1'b0;
		tm = 10'h000;
		po = 32'h0;
	endtask
	// Random group (AND, OR, XOR) with register, immediate or ROM operand
	task automatic logic_op();
		logic [1:0] g, f;
		logic [6:0] gc;
		logic [3:0] d;
		logic [9:0] r;
		g = 2'($urandom % 3);
		f = 2'($urandom % 3);
		gc = g == 0 ? GRP_AND : g == 1 ? GRP_OR : GRP_XOR;
		r = rf({pg, gr[16], gr[0]});
		d = f == 0 ? gr[{b, v}] : f == 1 ? v : (b ? r[3:0] : r[7:4]);
		if (f == 0) ins({gc, ~b, LO_REG_NIB, v});
		else if (f == 1) begin
			ins({gc, 1'b1, LO_IMM});
			ins({12'h000, v});
		end else ins({gc, b, LO_ROM});
		cy = g == 1 ? 1'b0 : acc[3] & d[3];
		acc = g == 0 ? acc & d : g == 1 ? acc | d : acc ^ d;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h0E4C));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 32; i++) begin
			gr[i] = 4'($urandom);
			axw(8'h80 + 8'(i * 4), 32'(gr[i]));
		end
		pg = 2'($urandom);
		axw(REG_CTRL, 32'(pg));
		chk(32'(rr), 32'(RESP_OKAY));
		axr(8'h18);
		chk(32'(rr), 32'(RESP_SLVERR));
		setacc(4'hF);
		ins(16'hF4F3);
		acc = 4'h0;
		cy = 1'b1;
		cmp_state();
		setacc(4'hF);
		ins(16'hFAF3);
		cy = 1'b1;
		cmp_state();
		for (int it = 0; it < 90; it++) begin
			port_in <= $urandom;
			status_in <= 4'($urandom);
			repeat (3) @(posedge aclk);
			b = 1'($urandom);
			k = 2'($urandom);
			v = 4'($urandom);
			ra = 11'($urandom);
			lo = 8'hF8 + 8'(k) + 8'(k > 1);
			case ($urandom % 9)
				0, 8: logic_op();
				1: begin
					ins(16'hF4F3);
					acc++;
					cy = acc == 4'h0;
				end
				2: begin
					ins(k == 1 ? 16'hFAF3 : (k[1] && acc != 0) ? 16'hFEF3 : 16'hFCF3);
					cy = k == 1 ? acc == 4'hF : acc[3];
					if (k != 1) acc = {acc[2:0], acc[3]};
				end
				3: begin
					if (b) ins(16'hE3F1);
					ins(b ? {12'h000, v} : {12'hE3E, v});
					fl = (b ? v : gr[v]) == status_in;
				end
				4: begin
					ins({GRP_IN, ~b, lo});
					acc = port_in[4 * {b, k} +: 4];
					cy = 1'b0;
				end
				5: begin
					ins({GRP_OUT, ~b, lo});
					po[4 * {b, k} +: 4] = acc;
				end
				6: case (k)
					2'h0: begin
						ins(16'hE5FF);
						tm = {tm[9:6], acc, tm[1], 1'b0};
					end
					2'h1: begin
						ins(16'hE4FF);
						tm = {acc, tm[5:2], 1'b0, tm[0]};
					end
					2'h2: begin
						ins(16'hE6FF);
						ins({6'h00, ra[9:0]});
						tm = ra[9:0];
					end
					default: begin
						ins(16'hF4FF);
						tm = rf({pg, gr[16], gr[0]});
					end
				endcase
				default: begin
					ins({7'h7F, b, 8'hFF});
					acc = b ? tm[5:2] : tm[9:6];
					cy = 1'b0;
				end
			endcase
			// Tags
			cmp_state();
		end
		axr(REG_CTRL);
		chk(32'(rd[1:0]), 32'(pg));
		// Call and return, then a return with nothing stacked
		ra = fetch_addr + 11'h003;
		ins(CODE_CALL);
		ins(CODE_PG0);
		ins(16'h0155);
		chk(32'(fetch_addr), 32'h155);
		ins(CODE_RET);
		chk(32'(fetch_addr), 32'(ra));
		ins(CODE_RET);
		wipe();
		cmp_state();
		chk(32'(nrst), 32'h1);
		// Nested call overflows the single stack level
		setacc(4'h5);
		ins(CODE_CALL);
		ins(CODE_PG1);
		ins(16'h0023);
		chk(32'(fetch_addr), 32'h423);
		ins(CODE_CALL);
		ins(CODE_PG0);
		ins(16'h0044);
		wipe();
		cmp_state();
		chk(32'(nrst), 32'h2);
		// Rotating a zero accumulator restarts the core
		setacc(4'h9);
		ins(16'hE5F8);
		setacc(4'h0);
		ins(16'hFEF3);
		wipe();
		cmp_state();
		chk(32'(nrst), 32'h3);
		// Standby left by a pin match, then by a software wake
		status_in <= 4'h0;
		repeat (3) @(posedge aclk);
		ins(16'hE2F1);
		ins(16'h0006);
		chk(32'(standby), 32'h1);
		status_in <= 4'h4;
		while (standby) @(posedge aclk);
		ins(16'hE2F1);
		ins(16'h0001);
		chk(32'(standby), 32'h1);
		axw(REG_CTRL, 32'h10 | 32'(pg));
		while (standby) @(posedge aclk);
		cmp_state();
		tally_and_finish();
	end
endmodule
`default_nettype wire
